// ===== design/lo_link_options.sv
// Link options control register with Avalon-MM slave and interrupt
`timescale 1ns/1ps
module lo_link_options #(
  parameter int unsigned BASE_CYCLES = lo_pkg::CYC_BASE_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [lo_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                      avs_read_i,
  input  wire logic                      avs_write_i,
  input  wire logic [31:0]               avs_writedata_i,
  input  wire logic [3:0]                avs_byteenable_i,
  output logic [31:0]                    avs_readdata_o,
  output logic                           avs_waitrequest_o,
  output logic                           irq_o,
  output lo_pkg::lo_ctl_type             ctl_o,
  input  wire logic                      access_fail_i,
  input  wire logic                      bus_reset_i,
  output logic                           bm_preload_o,
  input  wire logic                      root_i,
  output logic                           cycle_start_o,
  input  wire logic                      pw_req_i,
  input  wire logic                      pw_done_i,
  output logic                           pw_allow_o
);
  import lo_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_be

  function automatic logic [CNT_W-1:0] period_of(input logic [2:0] sel);
    logic [2:0] sh;
    sh = (sel > CP_MAX) ? 3'h0 : sel;
    return CNT_W'(BASE_CYCLES >> sh);
  endfunction : period_of

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                 ack_r,     ack_nxt;
  logic [31:0]          rdata_r,   rdata_nxt;
  logic [31:0]          loc_r,     loc_nxt;
  logic [IRQ_W-1:0]     ist_r,     ist_nxt;
  logic [IRQ_W-1:0]     imk_r,     imk_nxt;
  logic [2:0]           pw_cnt_r,  pw_cnt_nxt;
  logic [CNT_W-1:0]     cyc_cnt_r, cyc_cnt_nxt;
  logic                 cyc_r,     cyc_nxt;
  logic                 bmp_r,     bmp_nxt;
  logic                 req;
  logic                 wr_take;
  logic                 rd_take;
  logic [IRQ_W-1:0]     ev_set;
  logic [CNT_W-1:0]     period;
  lo_ctl_type           ctl;

  assign ctl     = lo_unpack(loc_r);
  assign req     = avs_read_i | avs_write_i;
  assign wr_take = avs_write_i & ack_r;
  assign rd_take = avs_read_i & ack_r;
  assign period  = period_of(ctl.cycle_sel);

  // ----------------------------------------------------------------
  // Bus slave: one wait state per access
  // ----------------------------------------------------------------
  always_comb begin
    ack_nxt   = req & ~ack_r;
    rdata_nxt = rdata_r;
    if (avs_read_i && !ack_r) begin
      case (avs_address_i)
        LOC_OFS: rdata_nxt = loc_r & LOC_WMASK;
        IST_OFS: rdata_nxt = 32'(ist_r);
        IMK_OFS: rdata_nxt = 32'(imk_r);
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  assign avs_waitrequest_o = req & ~ack_r;
  assign avs_readdata_o    = rdata_r;

  // ----------------------------------------------------------------
  // Registers and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    loc_nxt = loc_r;
    imk_nxt = imk_r;
    if (wr_take && avs_address_i == LOC_OFS) begin
      loc_nxt = merge_be(loc_r, avs_writedata_i, avs_byteenable_i) & LOC_WMASK;
    end
    if (wr_take && avs_address_i == IMK_OFS) begin
      imk_nxt = IRQ_W'(merge_be(32'(imk_r), avs_writedata_i, avs_byteenable_i));
    end
    ev_set             = '0;
    ev_set[IRQ_FAIL]   = access_fail_i & ctl.failed_access_irq_enable;
    ev_set[IRQ_PWDROP] = pw_req_i & ~pw_allow_o;
    ist_nxt = ist_r;
    if (rd_take && avs_address_i == IST_OFS) begin
      ist_nxt = ist_r & ~rdata_r[IRQ_W-1:0];
    end
    ist_nxt = ist_nxt | ev_set;
  end

  assign irq_o = |(ist_r & imk_r);
  assign ctl_o = ctl;

  // ----------------------------------------------------------------
  // Bus reset preload, posted writes, cycle timer
  // ----------------------------------------------------------------
  assign pw_allow_o = (ctl.pw_limit <= PW_MAX) && (pw_cnt_r < ctl.pw_limit);

  always_comb begin
    bmp_nxt    = bus_reset_i & ctl.bus_mgmt_preload_enable;
    pw_cnt_nxt = pw_cnt_r;
    if ((pw_req_i && pw_allow_o) && !(pw_done_i && pw_cnt_r != 3'h0)) begin
      pw_cnt_nxt = pw_cnt_r + 3'h1;
    end else if (!(pw_req_i && pw_allow_o) && pw_done_i && pw_cnt_r != 3'h0) begin
      pw_cnt_nxt = pw_cnt_r - 3'h1;
    end
    cyc_nxt     = 1'b0;
    cyc_cnt_nxt = cyc_cnt_r;
    if (!root_i) begin
      cyc_cnt_nxt = '0;
    end else if (cyc_cnt_r >= period - CNT_W'(1)) begin
      cyc_cnt_nxt = '0;
      cyc_nxt     = 1'b1;
    end else begin
      cyc_cnt_nxt = cyc_cnt_r + CNT_W'(1);
    end
  end

  assign bm_preload_o  = bmp_r;
  assign cycle_start_o = cyc_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r     <= 1'b0;
      rdata_r   <= 32'h00000000;
      loc_r     <= LOC_RESET;
      ist_r     <= IST_RESET[IRQ_W-1:0];
      imk_r     <= IMK_RESET[IRQ_W-1:0];
      pw_cnt_r  <= 3'h0;
      cyc_cnt_r <= '0;
      cyc_r     <= 1'b0;
      bmp_r     <= 1'b0;
    end else begin
      ack_r     <= ack_nxt;
      rdata_r   <= rdata_nxt;
      loc_r     <= loc_nxt;
      ist_r     <= ist_nxt;
      imk_r     <= imk_nxt;
      pw_cnt_r  <= pw_cnt_nxt;
      cyc_cnt_r <= cyc_cnt_nxt;
      cyc_r     <= cyc_nxt;
      bmp_r     <= bmp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_ctl_write;
    wr_take && avs_address_i == LOC_OFS && avs_byteenable_i[3];
  endsequence

  property p_fail_sets;
    @(posedge clk_i) disable iff (!rst_n_i)
      access_fail_i && ctl.failed_access_irq_enable |=> ist_r[IRQ_FAIL];
  endproperty
  a_fail_sets: assert property (p_fail_sets) else $error("failed access not flagged");

  property p_fail_gated;
    @(posedge clk_i) disable iff (!rst_n_i)
      !ist_r[IRQ_FAIL] && !(access_fail_i && ctl.failed_access_irq_enable) |=> !ist_r[IRQ_FAIL];
  endproperty
  a_fail_gated: assert property (p_fail_gated) else $error("failed access flagged while off");

  property p_preload;
    @(posedge clk_i) disable iff (!rst_n_i)
      bus_reset_i |=> bm_preload_o == $past(ctl.bus_mgmt_preload_enable);
  endproperty
  a_preload: assert property (p_preload) else $error("preload pulse wrong");

  property p_retry_wr;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_ctl_write |=> ctl_o.retry_processing_enable == $past(avs_writedata_i[RETRY_BIT]);
  endproperty
  a_retry_wr: assert property (p_retry_wr) else $error("retry enable not stored");

  property p_rsvd_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_take && avs_address_i == LOC_OFS |-> avs_readdata_o[RSVD_RO_BIT] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit reads one");

  property p_pw_limit;
    @(posedge clk_i) disable iff (!rst_n_i)
      pw_allow_o |-> pw_cnt_r < ctl.pw_limit;
  endproperty
  a_pw_limit: assert property (p_pw_limit) else $error("posted write over limit");

  property p_pw_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      ctl.pw_limit > PW_MAX |-> !pw_allow_o;
  endproperty
  a_pw_off: assert property (p_pw_off) else $error("posted write allowed above limit");

  property p_cycle_tick;
    @(posedge clk_i) disable iff (!rst_n_i)
      root_i && cyc_cnt_r == period - CNT_W'(1) |=> cycle_start_o && cyc_cnt_r == '0;
  endproperty
  a_cycle_tick: assert property (p_cycle_tick) else $error("cycle start missed");

  property p_code_map;
    @(posedge clk_i) disable iff (!rst_n_i)
      ctl.cycle_sel > CP_MAX |-> period == CNT_W'(BASE_CYCLES);
  endproperty
  a_code_map: assert property (p_code_map) else $error("undefined code period wrong");

  property p_wait;
    @(posedge clk_i) disable iff (!rst_n_i)
      req && !ack_r |-> avs_waitrequest_o ##1 (!req || !avs_waitrequest_o);
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");

  sequence s_ist_read;
    rd_take && avs_address_i == IST_OFS;
  endsequence

  property p_ist_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_ist_read and !(|ev_set) |=> (ist_r & $past(rdata_r[IRQ_W-1:0])) == '0;
  endproperty
  a_ist_clear: assert property (p_ist_clear) else $error("read status bit not cleared");

  property p_ist_keep;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_ist_read |=> (($past(ist_r) & ~$past(rdata_r[IRQ_W-1:0])) & ~ist_r) == '0;
  endproperty
  a_ist_keep: assert property (p_ist_keep) else $error("unread status bit lost");

  property p_set_wins;
    @(posedge clk_i) disable iff (!rst_n_i)
      |ev_set |=> (ist_r & $past(ev_set)) == $past(ev_set);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status event lost");

  property p_rev_wr;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_ctl_write |=> ctl_o.rev_features_enable == $past(avs_writedata_i[REV_BIT]);
  endproperty
  a_rev_wr: assert property (p_rev_wr) else $error("revision enable not stored");

  property p_rom_wr;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_ctl_write |=> ctl_o.rom_management_enable == $past(avs_writedata_i[ROM_BIT]);
  endproperty
  a_rom_wr: assert property (p_rom_wr) else $error("rom enable not stored");

  property p_twobuf_wr;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_ctl_write |=> ctl_o.ir_two_buffer_enable == $past(avs_writedata_i[TWOBUF_BIT]);
  endproperty
  a_twobuf_wr: assert property (p_twobuf_wr) else $error("two-buffer enable not stored");

  property p_itskip_wr;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_ctl_write |=> ctl_o.it_skip_underrun_enable == $past(avs_writedata_i[ITSKIP_BIT]);
  endproperty
  a_itskip_wr: assert property (p_itskip_wr) else $error("skip enable not stored");

  property p_preload_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      bus_reset_i && !ctl.bus_mgmt_preload_enable |=> !bm_preload_o;
  endproperty
  a_preload_off: assert property (p_preload_off) else $error("preload while disabled");

  property p_pw_count;
    @(posedge clk_i) disable iff (!rst_n_i)
      pw_req_i && pw_allow_o && !pw_done_i |=> pw_cnt_r == $past(pw_cnt_r) + 3'h1;
  endproperty
  a_pw_count: assert property (p_pw_count) else $error("posted write not counted");

  property p_short_period;
    @(posedge clk_i) disable iff (!rst_n_i)
      ctl.cycle_sel == 3'h4 |-> period == CNT_W'(BASE_CYCLES / 16);
  endproperty
  a_short_period: assert property (p_short_period) else $error("shortest period wrong");

  property p_cycle_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      !root_i |=> cyc_cnt_r == '0 && !cycle_start_o;
  endproperty
  a_cycle_off: assert property (p_cycle_off) else $error("cycle timer runs while not root");

endmodule : lo_link_options

// ===== design/lo_pkg.sv
// Constants and types for the link options control block
package lo_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] LOC_OFS      = 12'h840;
  localparam logic [11:0] IST_OFS      = 12'h844;
  localparam logic [11:0] IMK_OFS      = 12'h848;
  localparam logic [31:0] LOC_RESET    = 32'h00000020;
  localparam logic [31:0] LOC_WMASK    = 32'hBF00003F;
  localparam logic [31:0] IST_RESET    = 32'h00000000;
  localparam logic [31:0] IMK_RESET    = 32'h00000000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          REV_BIT      = 31;
  localparam int          FAIL_EN_BIT  = 29;
  localparam int          BMP_BIT      = 28;
  localparam int          RETRY_BIT    = 27;
  localparam int          ROM_BIT      = 26;
  localparam int          TWOBUF_BIT   = 25;
  localparam int          ITSKIP_BIT   = 24;
  localparam int          RSVD_RO_BIT  = 22;
  localparam int          PW_LSB       = 3;
  localparam int          CP_LSB       = 0;
  localparam logic [2:0]  PW_MAX       = 3'h4;
  localparam logic [2:0]  CP_MAX       = 3'h4;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int          IRQ_W        = 2;
  localparam int          IRQ_FAIL     = 0;
  localparam int          IRQ_PWDROP   = 1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_NS       = 20;
  localparam int          CYC_BASE_NS  = 125000;
  localparam int          CYC_BASE_CYC = CYC_BASE_NS / CLK_NS;
  localparam int          CNT_W        = 16;

  typedef struct packed {
    logic       rev_features_enable;
    logic       failed_access_irq_enable;
    logic       bus_mgmt_preload_enable;
    logic       retry_processing_enable;
    logic       rom_management_enable;
    logic       ir_two_buffer_enable;
    logic       it_skip_underrun_enable;
    logic [2:0] pw_limit;
    logic [2:0] cycle_sel;
  } lo_ctl_type;

  function automatic lo_ctl_type lo_unpack(input logic [31:0] r);
    lo_ctl_type c;
    c.rev_features_enable      = r[REV_BIT];
    c.failed_access_irq_enable = r[FAIL_EN_BIT];
    c.bus_mgmt_preload_enable  = r[BMP_BIT];
    c.retry_processing_enable  = r[RETRY_BIT];
    c.rom_management_enable    = r[ROM_BIT];
    c.ir_two_buffer_enable     = r[TWOBUF_BIT];
    c.it_skip_underrun_enable  = r[ITSKIP_BIT];
    c.pw_limit                 = r[PW_LSB +: 3];
    c.cycle_sel                = r[CP_LSB +: 3];
    return c;
  endfunction : lo_unpack

endpackage : lo_pkg

// ===== verif/lo_link_options_bench.sv
// Self-checking bench for the link options control block
`timescale 1ns/1ps
module lo_link_options_bench;
  import lo_pkg::*;

  // --------------------------------------------------------------
  // Signals and instance
  // --------------------------------------------------------------
  logic              clk_i;
  logic              rst_n_i;
  logic [ADDR_W-1:0] avs_address_i;
  logic              avs_read_i;
  logic              avs_write_i;
  logic [31:0]       avs_writedata_i;
  logic [3:0]        avs_byteenable_i;
  logic [31:0]       avs_readdata_o;
  logic              avs_waitrequest_o;
  logic              irq_o;
  lo_ctl_type        ctl_o;
  logic              access_fail_i;
  logic              bus_reset_i;
  logic              bm_preload_o;
  logic              root_i;
  logic              cycle_start_o;
  logic              pw_req_i;
  logic              pw_done_i;
  logic              pw_allow_o;
  int                n_mismatch;
  int                total_checks;
  logic [31:0]       rd;
  int                n;

  lo_link_options #(.BASE_CYCLES(64)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
    .ctl_o(ctl_o), .access_fail_i(access_fail_i), .bus_reset_i(bus_reset_i),
    .bm_preload_o(bm_preload_o), .root_i(root_i), .cycle_start_o(cycle_start_o),
    .pw_req_i(pw_req_i), .pw_done_i(pw_done_i), .pw_allow_o(pw_allow_o)
  );

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic w;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_read_i      <= ~wr;
    avs_write_i     <= wr;
    do begin
      @(negedge clk_i);
      w = avs_waitrequest_o;
      @(posedge clk_i);
    end while (w !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : access

  // Drives {access_fail, bus_reset, pw_req, pw_done} for one cycle
  task automatic pulse(input logic [3:0] sel);
    @(posedge clk_i);
    {access_fail_i, bus_reset_i, pw_req_i, pw_done_i} <= sel;
    @(posedge clk_i);
    {access_fail_i, bus_reset_i, pw_req_i, pw_done_i} <= 4'h0;
    @(negedge clk_i);
  endtask : pulse

  task automatic conclude;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // --------------------------------------------------------------
  // Clock, reset, watchdog
  // --------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    avs_address_i = 12'h000;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h00000000;
    avs_byteenable_i = 4'hF;
    {access_fail_i, bus_reset_i, pw_req_i, pw_done_i} = 4'h0;
    root_i = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    access(1'b0, LOC_OFS, 32'h0);
    chk(rd, 32'h00000020);
    chk({19'h0, ctl_o}, 32'h00000020);
    chk({31'h0, pw_allow_o}, 32'h1);
    access(1'b1, 12'h900, 32'hFFFFFFFF);
    access(1'b0, 12'h900, 32'h0);
    chk(rd, 32'h00000000);
    access(1'b1, LOC_OFS, 32'hBF40003F);
    access(1'b0, LOC_OFS, 32'h0);
    chk(rd, 32'hBF00003F);
    chk({19'h0, ctl_o}, 32'h00001FFF);
    chk({31'h0, pw_allow_o}, 32'h0);
    // Failed access interrupt, limit of one posted write
    access(1'b1, IMK_OFS, 32'h00000003);
    access(1'b1, LOC_OFS, 32'h20000008);
    pulse(4'h8);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    access(1'b0, IST_OFS, 32'h0);
    chk(rd, 32'h00000001);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    chk({31'h0, pw_allow_o}, 32'h1);
    pulse(4'h2);
    chk({31'h0, pw_allow_o}, 32'h0);
    pulse(4'h2);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    access(1'b0, IST_OFS, 32'h0);
    chk(rd, 32'h00000002);
    pulse(4'h1);
    chk({31'h0, pw_allow_o}, 32'h1);
    access(1'b1, LOC_OFS, 32'h00000028);
    @(negedge clk_i);
    chk({31'h0, pw_allow_o}, 32'h0);
    // Interrupt gate cleared
    access(1'b1, LOC_OFS, 32'h00000000);
    pulse(4'h8);
    access(1'b0, IST_OFS, 32'h0);
    chk(rd, 32'h00000000);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    // Bus management preload
    access(1'b1, LOC_OFS, 32'h10000000);
    pulse(4'h4);
    chk({31'h0, bm_preload_o}, 32'h1);
    access(1'b1, LOC_OFS, 32'h00000000);
    pulse(4'h4);
    chk({31'h0, bm_preload_o}, 32'h0);
    // Cycle period for every code
    for (int code = 0; code < 8; code++) begin
      @(posedge clk_i);
      root_i <= 1'b0;
      access(1'b1, LOC_OFS, code);
      access(1'b0, LOC_OFS, 32'h0);
      chk(rd, code);
      root_i <= 1'b1;
      @(negedge clk_i);
      while (cycle_start_o !== 1'b1) @(negedge clk_i);
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (cycle_start_o !== 1'b1);
      chk(n, (code <= 4) ? (64 >> code) : 64);
    end
    access(1'b1, LOC_OFS, 32'h00000020);
    access(1'b0, LOC_OFS, 32'h0);
    chk(rd, 32'h00000020);
    conclude();
  end

endmodule : lo_link_options_bench
